// ===== design/pin_fmt_params.svh
// offsets, field positions, reset values and timing counts of the pin format block
`ifndef PIN_FMT_PARAMS_SVH
`define PIN_FMT_PARAMS_SVH
`define PIN_COUNT 5
// register indices; byte address is four times the index
`define IDX_PIN_CFG 8'h4d
`define IDX_OUT_DATA 8'h4e
`define IDX_LEVELS 8'h50
`define IDX_PWM_BASE 8'h60
`define CFG_RESET 16'h0000
`define CFG_WR_MASK 16'h7ffd
`define CFG_RSVD_BIT 15
`define CFG_FMT_LSB 10
`define CFG_DIR_LSB 5
`define CFG_SRC_LSB 0
`define OUT_DATA_RESET 5'h00
`define PWM_CFG_RESET 16'h007f
`define CNT_MAX 8'hff
`define CLK_PERIOD_NS 100
`endif

// ===== design/pin_fmt_pkg.sv
// types shared by the pin format block
package pin_fmt_pkg;
  typedef struct packed {
    logic [1:0] time_base;
    logic [6:0] high_period;
    logic [6:0] low_period;
  } pin_pwm_cfg_t;
  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_low = 2'b01,
    ph_high = 2'b10
  } pwm_phase_t;
endpackage

// ===== design/pin_format_static_pwm_select.sv
// five-pin static/pwm format select with apb register access
//
// Function
// - reserved top bit of the pin configuration register always reads zero.
// - one read-write format bit per pin, bits 14 down to 10, reset zero.
// - format zero input pin takes its value from the static level.
// - format zero output pin on the gpio source drives static level, pwm period settings ignored.
// - format zero readback path interprets the pin by static level.
// - format one input pin value comes from decoding its pwm waveform.
// - format one output pin on the gpio source generates pwm from its low and high periods.
// - format one readback decodes pwm using the pin's own time base.
// - direction bit zero makes pin an input, one an output.
// - output data bit sets level only for plain digital outputs.
`timescale 1ns/1ps
`include "pin_fmt_params.svh"
module pin_format_static_pwm_select (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and alternate functions
  input wire logic [4:0] pin_in,
  input wire logic [4:0] alt_func_out,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe
);
  import pin_fmt_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] cfg_reg;
  logic [4:0] out_data_reg;
  pin_pwm_cfg_t pwm_cfg_reg [0:4];
  logic [4:0] level_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [4:0] pin_out_reg;
  logic [4:0] pin_oe_reg;
  logic [5:0] presc_reg;
  logic [4:0] in_prev_reg;
  logic [7:0] hi_cnt_reg [0:4];
  logic [7:0] lo_cnt_reg [0:4];
  logic [7:0] lo_last_reg [0:4];
  pwm_phase_t phase_reg [0:4];
  logic [6:0] gen_cnt_reg [0:4];

  wire logic [4:0] fmt = cfg_reg[`CFG_FMT_LSB +: `PIN_COUNT];
  wire logic [4:0] dir = cfg_reg[`CFG_DIR_LSB +: `PIN_COUNT];
  // pin 1 has no alternate function, so it is always the plain gpio source
  wire logic [4:0] gpio_src = cfg_reg[`CFG_SRC_LSB +: `PIN_COUNT] | 5'h02;
  wire logic [7:0] idx = paddr[9:2];
  wire logic wr_en = psel & penable & pready_reg & pwrite & ~pslverr_reg;

  // tick of the pin's time base: divide by 1, 4, 16 or 64
  function automatic logic tb_tick(input logic [5:0] presc, input logic [1:0] tb);
    logic [5:0] mask;
    mask = 6'h00;
    case (tb)
      2'b00: mask = 6'h00;
      2'b01: mask = 6'h03;
      2'b10: mask = 6'h0f;
      default: mask = 6'h3f;
    endcase
    return (presc & mask) == 6'h00;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] i);
    return (i == `IDX_PIN_CFG) || (i == `IDX_OUT_DATA) || (i == `IDX_LEVELS) ||
      ((i >= `IDX_PWM_BASE) && (i < `IDX_PWM_BASE + 8'h05));
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == `CNT_MAX) ? v : v + 8'h01;
  endfunction

  // ----------------------------------------------------------------
  // apb slave: no wait states, answer registered from the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= psel & ~penable;
      if (psel && !penable) begin
        pslverr_reg <= ~addr_mapped(idx) | (paddr[1:0] != 2'b00);
        prdata_reg <= 32'h00000000;
        if (idx == `IDX_PIN_CFG) begin
          prdata_reg <= {16'h0000, cfg_reg & `CFG_WR_MASK};
        end else if (idx == `IDX_OUT_DATA) begin
          prdata_reg <= {27'h0000000, out_data_reg};
        end else if (idx == `IDX_LEVELS) begin
          prdata_reg <= {27'h0000000, level_reg};
        end else if (addr_mapped(idx)) begin
          prdata_reg <= {16'h0000, pwm_cfg_reg[3'(idx - `IDX_PWM_BASE)]};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `CFG_RESET;
      out_data_reg <= `OUT_DATA_RESET;
      for (int n = 0; n < `PIN_COUNT; n++) begin
        pwm_cfg_reg[n] <= `PWM_CFG_RESET;
      end
    end else if (wr_en) begin
      if (idx == `IDX_PIN_CFG) begin
        cfg_reg <= pwdata[15:0] & `CFG_WR_MASK;
      end else if (idx == `IDX_OUT_DATA) begin
        out_data_reg <= pwdata[4:0];
      end else if (idx >= `IDX_PWM_BASE) begin
        pwm_cfg_reg[3'(idx - `IDX_PWM_BASE)] <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // input decoding, shared by input pins and output readback
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= 6'h00;
      in_prev_reg <= 5'h00;
      level_reg <= 5'h00;
      for (int n = 0; n < `PIN_COUNT; n++) begin
        hi_cnt_reg[n] <= 8'h00;
        lo_cnt_reg[n] <= 8'h00;
        lo_last_reg[n] <= 8'h00;
      end
    end else begin
      presc_reg <= presc_reg + 6'h01;
      in_prev_reg <= pin_in;
      for (int n = 0; n < `PIN_COUNT; n++) begin
        if (!fmt[n]) begin
          level_reg[n] <= pin_in[n];
          hi_cnt_reg[n] <= 8'h00;
          lo_cnt_reg[n] <= 8'h00;
        end else begin
          // a cycle counts as high when the high part outlasts the low part
          if (in_prev_reg[n] && !pin_in[n]) begin
            level_reg[n] <= hi_cnt_reg[n] > lo_last_reg[n];
            lo_cnt_reg[n] <= 8'h00;
          end else if (!in_prev_reg[n] && pin_in[n]) begin
            lo_last_reg[n] <= lo_cnt_reg[n];
            hi_cnt_reg[n] <= 8'h00;
          end else if (tb_tick(presc_reg, pwm_cfg_reg[n].time_base)) begin
            if (pin_in[n]) begin
              hi_cnt_reg[n] <= sat_inc(hi_cnt_reg[n]);
            end else begin
              lo_cnt_reg[n] <= sat_inc(lo_cnt_reg[n]);
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pwm generation; a period of zero is stretched to one tick
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < `PIN_COUNT; n++) begin
        phase_reg[n] <= ph_idle;
        gen_cnt_reg[n] <= 7'h00;
      end
    end else begin
      for (int n = 0; n < `PIN_COUNT; n++) begin
        if (!(fmt[n] && dir[n] && gpio_src[n])) begin
          phase_reg[n] <= ph_idle;
          gen_cnt_reg[n] <= 7'h00;
        end else begin
          case (phase_reg[n])
            ph_idle: begin
              phase_reg[n] <= ph_low;
              gen_cnt_reg[n] <= 7'h00;
            end
            ph_low: begin
              if (tb_tick(presc_reg, pwm_cfg_reg[n].time_base)) begin
                if (gen_cnt_reg[n] + 7'h01 >= pwm_cfg_reg[n].low_period) begin
                  phase_reg[n] <= ph_high;
                  gen_cnt_reg[n] <= 7'h00;
                end else begin
                  gen_cnt_reg[n] <= gen_cnt_reg[n] + 7'h01;
                end
              end
            end
            ph_high: begin
              if (tb_tick(presc_reg, pwm_cfg_reg[n].time_base)) begin
                if (gen_cnt_reg[n] + 7'h01 >= pwm_cfg_reg[n].high_period) begin
                  phase_reg[n] <= ph_low;
                  gen_cnt_reg[n] <= 7'h00;
                end else begin
                  gen_cnt_reg[n] <= gen_cnt_reg[n] + 7'h01;
                end
              end
            end
            default: phase_reg[n] <= ph_idle;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 5'h00;
      pin_oe_reg <= 5'h00;
    end else begin
      pin_oe_reg <= dir;
      for (int n = 0; n < `PIN_COUNT; n++) begin
        if (!dir[n]) begin
          pin_out_reg[n] <= 1'b0;
        end else if (!gpio_src[n]) begin
          pin_out_reg[n] <= alt_func_out[n];
        end else if (fmt[n]) begin
          pin_out_reg[n] <= phase_reg[n] == ph_high;
        end else begin
          pin_out_reg[n] <= out_data_reg[n];
        end
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reserved_zero: assert property (!cfg_reg[15] && !prdata[31])
    else $error("reserved configuration bit not zero");
  a_fmt_write: assert property (wr_en && idx == `IDX_PIN_CFG |=>
    fmt == $past(pwdata[14:10]))
    else $error("format bits did not take written value");
  a_static_input: assert property (!fmt[0] ##1 !fmt[0] |->
    level_reg[0] == $past(pin_in[0]))
    else $error("static level not followed");
  a_pwm_ignored: assert property (!fmt[2] |=> phase_reg[2] == ph_idle)
    else $error("pwm generator active in static format");
  a_static_drive: assert property (dir[1] && !fmt[1] ##1 dir[1] && !fmt[1] |=>
    pin_out[1] == $past(out_data_reg[1]))
    else $error("static output level wrong");
  // a config write in the same cycle may drop the pin out of pwm before the level shows
  a_pwm_edge: assert property (phase_reg[1] == ph_low && fmt[1] && dir[1] && gpio_src[1] &&
    !(wr_en && idx == `IDX_PIN_CFG) && tb_tick(presc_reg, pwm_cfg_reg[1].time_base) &&
    gen_cnt_reg[1] + 7'h01 >= pwm_cfg_reg[1].low_period |=>
    phase_reg[1] == ph_high ##1 pin_out[1])
    else $error("pwm low period not ended");
  a_pwm_decode: assert property (fmt[0] && in_prev_reg[0] && !pin_in[0] |=>
    level_reg[0] == ($past(hi_cnt_reg[0]) > $past(lo_last_reg[0])))
    else $error("pwm decode wrong");
  a_dir_enable: assert property (##1 pin_oe == $past(dir))
    else $error("output enable does not follow direction");
  a_input_quiet: assert property (!dir[4] |=> !pin_out[4] && !pin_oe[4])
    else $error("input pin driven");

  c_cfg_write: cover property (wr_en && idx == `IDX_PIN_CFG && pwdata[14]);
  c_pwm_out: cover property (fmt[1] && dir[1] && $rose(pin_out[1]));
  c_pwm_in_high: cover property (fmt[0] && $rose(level_reg[0]));
  c_bad_addr: cover property (pready && pslverr);
endmodule

// ===== dv/pin_partner.sv
// model of the external circuit on the five pins
`timescale 1ns/1ps
module pin_partner (
  // clock
  input wire logic pclk,
  // pins
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  output logic [4:0] pin_in,
  // scenario control
  input wire logic [4:0] lvl,
  input wire logic [4:0] pwm_en,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len
);
  logic [7:0] cnt = 8'h00;
  logic wave = 1'b0;
  // one shared waveform, lengths in pclk cycles
  always_ff @(posedge pclk) begin
    if (cnt + 8'h01 >= (wave ? hi_len : lo_len)) begin
      cnt <= 8'h00;
      wave <= ~wave;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  // a driven pin reads back its own level, as a board loopback would
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (pwm_en[i] ? wave : lvl[i]);
    end
  end
endmodule

// ===== dv/pin_format_static_pwm_select_test.sv
// self-checking bench for the pin format block
`timescale 1ns/1ps
`include "pin_fmt_params.svh"
module pin_format_static_pwm_select_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] pin_in;
  logic [4:0] alt = 5'h00;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  logic [4:0] lvl = 5'h00;
  logic [4:0] pwm_en = 5'h00;
  logic [7:0] hi_len = 8'h02;
  logic [7:0] lo_len = 8'h02;
  int bad_count = 0;
  int checks = 0;
  logic [31:0] rdv;
  logic err;
  int n;

  pin_format_static_pwm_select u_pin_format_static_pwm_select (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .alt_func_out(alt), .pin_out(pin_out), .pin_oe(pin_oe));
  pin_partner u_pin_partner (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .lvl(lvl), .pwm_en(pwm_en), .hi_len(hi_len), .lo_len(lo_len));

  initial begin
    forever #(`CLK_PERIOD_NS / 2) pclk = ~pclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tmo;
    bad_count++;
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) tmo();
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdv, exp);
  endtask

  task automatic wait_clk(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // length of the next high run on pin 1
  task automatic high_run;
    int k;
    n = 0;
    for (k = 0; k < 400 && pin_out[1] !== 1'b0; k++) @(posedge pclk);
    if (k == 400) tmo();
    for (k = 0; k < 400 && pin_out[1] !== 1'b1; k++) @(posedge pclk);
    if (k == 400) tmo();
    while (pin_out[1] === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk(`IDX_PIN_CFG, 32'h0);
    rd_chk(`IDX_OUT_DATA, 32'h0);
    for (int i = 0; i < 5; i++) rd_chk(8'(`IDX_PWM_BASE + i), 32'h7f);
    chk({27'h0, pin_oe}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_cfg_bits;
    apb(1'b1, `IDX_PIN_CFG, 32'hffff);
    rd_chk(`IDX_PIN_CFG, 32'h7ffd);
    apb(1'b1, `IDX_PIN_CFG, 32'h8000);
    rd_chk(`IDX_PIN_CFG, 32'h0);
    apb(1'b0, 8'h7f, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test config bits done");
  endtask

  task automatic t_static;
    lvl <= 5'h15;
    wait_clk(4);
    rd_chk(`IDX_LEVELS, 32'h15);
    apb(1'b1, `IDX_PWM_BASE + 8'h01, 32'h0102);
    apb(1'b1, `IDX_OUT_DATA, 32'h2);
    apb(1'b1, `IDX_PIN_CFG, 32'h0040);
    wait_clk(2);
    chk({27'h0, pin_oe}, 32'h2);
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      chk({31'h0, pin_out[1]}, 32'h1);
    end
    rd_chk(`IDX_LEVELS, 32'h17);
    $display("test static done");
  endtask

  task automatic t_pwm_out;
    apb(1'b1, `IDX_PIN_CFG, 32'h0840);
    for (int tb = 0; tb < 2; tb++) begin
      apb(1'b1, `IDX_PWM_BASE + 8'h01, {16'h0, tb[1:0], 7'd3, 7'd2});
      high_run();
      high_run();
      chk(n, tb ? 32'd12 : 32'd3);
    end
    wait_clk(60);
    rd_chk(`IDX_LEVELS, 32'h17);
    $display("test pwm output done");
  endtask

  task automatic t_pwm_in;
    apb(1'b1, `IDX_PIN_CFG, 32'h0400);
    pwm_en <= 5'h01;
    hi_len <= 8'h06;
    wait_clk(40);
    rd_chk(`IDX_LEVELS, 32'h15);
    hi_len <= 8'h02;
    lo_len <= 8'h06;
    wait_clk(40);
    rd_chk(`IDX_LEVELS, 32'h14);
    pwm_en <= 5'h00;
    $display("test pwm input done");
  endtask

  task automatic t_alt;
    apb(1'b1, `IDX_PIN_CFG, 32'h0020);
    apb(1'b1, `IDX_OUT_DATA, 32'h1);
    for (int a = 0; a < 2; a++) begin
      alt <= a[4:0];
      wait_clk(3);
      chk({31'h0, pin_out[0]}, a);
    end
    alt <= 5'h00;
    apb(1'b1, `IDX_PIN_CFG, 32'h0021);
    wait_clk(3);
    chk({31'h0, pin_out[0]}, 32'h1);
    $display("test alternate done");
  endtask

  // reset in mid-run must restore configuration and release the pins
  task automatic t_mid_reset;
    presetn <= 1'b0;
    wait_clk(2);
    presetn <= 1'b1;
    chk({27'h0, pin_oe}, 32'h0);
    rd_chk(`IDX_PIN_CFG, 32'h0);
    rd_chk(`IDX_PWM_BASE + 8'h01, 32'h7f);
    $display("test mid reset done");
  endtask

  initial begin
    wait_clk(5);
    presetn <= 1'b1;
    t_reset();
    t_cfg_bits();
    t_static();
    t_pwm_out();
    t_pwm_in();
    t_alt();
    t_mid_reset();
    give_verdict();
  end
endmodule
